// File: exa_phy_end.sv
// Device end: direct and indirect register access plus strap capture.
//
// Design decision made here: the address-and-strobe port.
`include "exa_consts.svh"
`timescale 1ns/100ps
module exa_phy_end (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   exa_mgmt_if.phy mgmt,
   input wire logic [2:0] strap_mac_i,
   input wire logic strap_ms_i,
   input wire logic strap_auto_i,
   input wire logic [1:0] strap_rxctrl_lvl_i,
   input wire logic [1:0] strap_strp1_lvl_i,
   output logic [2:0] mac_mode_o,
   output logic master_o,
   output logic managed_o,
   output logic [3:0] phy_addr_o
);

   // Maps a space select code to {supported, index}.
   function automatic logic [2:0] space_lookup(input logic [4:0] sel);
      logic [2:0] r;
      r = 3'h0;
      unique case (sel)
         `EXA_SPACE_STD: r = 3'h4;
         `EXA_SPACE_PMA: r = 3'h5;
         `EXA_SPACE_VA: r = 3'h6;
         `EXA_SPACE_VB: r = 3'h7;
         default: r = 3'h0;
      endcase
      return r;
   endfunction

   // Turns a three-level strap code into {upper, lower} address bits.
   // Mode 1 gives 00, mode 2 gives 10, mode 3 gives 11; code 11 is read as mode 1.
   function automatic logic [1:0] lvl_decode(input logic [1:0] lvl);
      logic [1:0] r;
      r = 2'h0;
      unique case (lvl)
         2'h1: r = 2'h2;
         2'h2: r = 2'h3;
         default: r = 2'h0;
      endcase
      return r;
   endfunction

   logic [15:0] ctrl; // Indirect control register.
   logic [15:0] ptr; // Extended address pointer, sixteen bits wide.
   logic [15:0] dreg [0:31]; // Directly addressed registers.
   logic [15:0] ext [0:63]; // Extended storage, sixteen words per space.
   logic ack; // Registered answer strobe.
   logic [15:0] rdata; // Registered read data.
   logic cap_pend; // Strap capture still owed after a reset.
   logic srst; // Command reset pulse from the reset register.
   logic [8:0] sync1; // First synchroniser stage for the strap pins.
   logic [8:0] sync2; // Second synchroniser stage, the only one logic reads.
   logic [2:0] mac_mode;
   logic master;
   logic managed;
   logic [3:0] phy_addr;
   logic [15:0] next_ctrl;
   logic [15:0] next_ptr;
   logic [15:0] next_dreg [0:31];
   logic [15:0] next_ext [0:63];
   logic next_ack;
   logic [15:0] next_rdata;
   logic next_cap_pend;
   logic next_srst;
   logic [2:0] next_mac_mode;
   logic next_master;
   logic next_managed;
   logic [3:0] next_phy_addr;
   exa_pkg::exa_fn_t fn; // Decoded access function.
   logic [2:0] sp; // Decoded space, support flag on top.
   logic [5:0] eidx; // Index into the extended storage.
   logic [1:0] rx_bits;
   logic [1:0] st_bits;

   assign fn = exa_pkg::exa_fn_t'(ctrl[`EXA_FN_MSB:`EXA_FN_LSB]);
   assign sp = space_lookup(ctrl[`EXA_SP_MSB:0]);
   // The storage is small, so only the low pointer bits pick the word.
   assign eidx = {sp[1:0], ptr[`EXA_EXT_AW-1:0]};

   // Strap pins come from outside and have no reset, so they are settled
   // by the time a held reset releases and the capture reads them.
   always_ff @(posedge clk_sys_i) begin
      sync1 <= {strap_mac_i, strap_ms_i, strap_auto_i, strap_rxctrl_lvl_i, strap_strp1_lvl_i};
      sync2 <= sync1;
   end

   // Next-state logic for registers, pointer, answer and strap capture.
   always_comb begin
      next_ctrl = ctrl;
      next_ptr = ptr;
      next_dreg = dreg;
      next_ext = ext;
      next_ack = 1'b0;
      next_rdata = rdata;
      next_cap_pend = cap_pend;
      next_srst = 1'b0;
      rx_bits = lvl_decode(sync2[3:2]);
      st_bits = lvl_decode(sync2[1:0]);
      if (mgmt.req) begin
         next_ack = 1'b1;
         if (mgmt.reg_addr == `EXA_CTRL_IDX) begin
            // The control register is always stored, even with a bad space code.
            if (mgmt.wr) begin
               next_ctrl = mgmt.wdata;
            end else begin
               next_rdata = ctrl;
            end
         end else if (mgmt.reg_addr == `EXA_DATA_IDX) begin
            if (!sp[2]) begin
               // Unknown space: writes dropped, reads answer zero.
               next_rdata = 16'h0000;
            end else if (fn == exa_pkg::FN_ADDR) begin
               if (mgmt.wr) begin
                  next_ptr = mgmt.wdata;
               end else begin
                  next_rdata = ptr;
               end
            end else begin
               if (mgmt.wr) begin
                  next_ext[eidx] = mgmt.wdata;
               end else begin
                  next_rdata = ext[eidx];
               end
               // Wrap past 16'hffff is not meant to be relied on.
               if (fn == exa_pkg::FN_DATA_INC_RW) begin
                  next_ptr = ptr + 16'h0001;
               end else if (fn == exa_pkg::FN_DATA_INC_WR && mgmt.wr) begin
                  next_ptr = ptr + 16'h0001;
               end
            end
         end else begin
            if (mgmt.wr) begin
               next_dreg[mgmt.reg_addr] = mgmt.wdata;
               if (mgmt.reg_addr == `EXA_RST_IDX) begin
                  // The reset bit clears itself, so it is never stored.
                  next_dreg[mgmt.reg_addr][`EXA_RST_BIT] = 1'b0;
                  next_srst = mgmt.wdata[`EXA_RST_BIT];
               end
            end else begin
               next_rdata = dreg[mgmt.reg_addr];
            end
         end
      end
      if (srst) begin
         // A command reset clears the indirect state and re-samples the straps.
         next_ctrl = 16'h0000;
         next_ptr = 16'h0000;
         next_cap_pend = 1'b1;
      end else if (cap_pend) begin
         // Config word: phy address in 8:5, managed 4, master 3, mac select 2:0.
         next_dreg[`EXA_CFG_IDX] = {7'h00, st_bits[1], rx_bits[1], st_bits[0], rx_bits[0],
            sync2[4], sync2[5], sync2[8:6]};
         next_cap_pend = 1'b0;
      end
      // Outputs follow the config register, which software may rewrite.
      next_mac_mode = next_dreg[`EXA_CFG_IDX][2:0];
      next_master = next_dreg[`EXA_CFG_IDX][3];
      next_managed = next_dreg[`EXA_CFG_IDX][4];
      next_phy_addr = next_dreg[`EXA_CFG_IDX][8:5];
   end

   // Register stage; the pin reset arms a strap capture for its release.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl <= 16'h0000;
         ptr <= 16'h0000;
         for (int i = 0; i < 32; i++) begin
            dreg[i] <= 16'h0000;
         end
         for (int j = 0; j < 64; j++) begin
            ext[j] <= 16'h0000;
         end
         ack <= 1'b0;
         rdata <= 16'h0000;
         cap_pend <= 1'b1;
         srst <= 1'b0;
         mac_mode <= 3'h0;
         master <= 1'b0;
         managed <= 1'b0;
         phy_addr <= 4'h0;
      end else begin
         ctrl <= next_ctrl;
         ptr <= next_ptr;
         dreg <= next_dreg;
         ext <= next_ext;
         ack <= next_ack;
         rdata <= next_rdata;
         cap_pend <= next_cap_pend;
         srst <= next_srst;
         mac_mode <= next_mac_mode;
         master <= next_master;
         managed <= next_managed;
         phy_addr <= next_phy_addr;
      end
   end

   assign mgmt.ack = ack;
   assign mgmt.rdata = rdata;
   assign mac_mode_o = mac_mode;
   assign master_o = master;
   assign managed_o = managed;
   assign phy_addr_o = phy_addr;
endmodule

// File: exa_consts.svh
// Constants shared by both ends of the indirect register access link.
`ifndef EXA_CONSTS_SVH
`define EXA_CONSTS_SVH
`define EXA_REG_AW 5
`define EXA_DATA_W 16
`define EXA_CTRL_IDX 5'h0d
`define EXA_DATA_IDX 5'h0e
`define EXA_CFG_IDX 5'h11
`define EXA_RST_IDX 5'h1f
`define EXA_RST_BIT 15
`define EXA_FN_MSB 15
`define EXA_FN_LSB 14
`define EXA_SP_MSB 4
`define EXA_SPACE_STD 5'h1f
`define EXA_SPACE_PMA 5'h01
`define EXA_SPACE_VA 5'h03
`define EXA_SPACE_VB 5'h07
`define EXA_EXT_AW 4
`define EXA_NIBBLE_MASK 16'h0fff
`define EXA_SW_CMD 3'h0
`define EXA_SW_WDATA 3'h1
`define EXA_SW_RDATA 3'h2
`define EXA_SW_STATUS 3'h3
`define EXA_SW_EXT_ADDR 3'h4
`define EXA_SW_EXT_CTRL 3'h5
`define EXA_CMD_WR_BIT 8
`define EXA_CMD_EXT_BIT 9
`define EXA_EXT_SKIP_BIT 13
`endif

// File: exa_pkg.sv
// Types shared by both ends of the indirect register access link.
package exa_pkg;
   // Access function held in the top two bits of the indirect control register.
   typedef enum logic [1:0] {FN_ADDR, FN_DATA, FN_DATA_INC_RW, FN_DATA_INC_WR} exa_fn_t;
   // Manager sequencing states.
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} exa_state_t;
endpackage

// File: exa_mgmt_if.sv
// Register-level management link between the manager and the device.
`timescale 1ns/100ps
interface exa_mgmt_if;
   logic req; // One-cycle access request from the manager.
   logic wr; // High for a write, low for a read.
   logic [4:0] reg_addr; // Direct register address.
   logic [15:0] wdata; // Write data.
   logic ack; // One-cycle answer from the device.
   logic [15:0] rdata; // Read data, valid with ack.
   modport mgr (output req, output wr, output reg_addr, output wdata, input ack, input rdata);
   modport phy (input req, input wr, input reg_addr, input wdata, output ack, output rdata);
endinterface

// File: exa_mgr_end.sv
// Manager end: software command port driving direct and extended accesses.
`include "exa_consts.svh"
`timescale 1ns/100ps
module exa_mgr_end (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   exa_mgmt_if.mgr mgmt,
   input wire logic [2:0] sw_addr_i,
   input wire logic [15:0] sw_wdata_i,
   input wire logic sw_wr_i,
   input wire logic sw_rd_i,
   output logic [15:0] sw_rdata_o
);

   exa_pkg::exa_state_t state;
   exa_pkg::exa_state_t next_state;
   logic [1:0] step; // Extended sequence step: ctrl, address, ctrl, data.
   logic [1:0] next_step;
   logic ext_op; // Current command runs the indirect sequence.
   logic next_ext_op;
   logic op_wr; // Current command is a write.
   logic next_op_wr;
   logic [4:0] op_reg; // Direct register of a direct command.
   logic [4:0] next_op_reg;
   logic [15:0] wdata_r, next_wdata_r; // Software write data.
   logic [15:0] ext_addr, next_ext_addr; // Extended register address.
   logic [15:0] ext_ctrl, next_ext_ctrl; // Function, space and skip flag.
   logic [15:0] result, next_result; // Last read result.
   logic done, next_done; // Sticky completion flag.
   logic req, next_req;
   logic wr, next_wr;
   logic [4:0] reg_addr, next_reg_addr;
   logic [15:0] wdata, next_wdata;
   logic [15:0] rdata_o, next_rdata_o;

   // Next-state logic: software port, sequencer and link drive.
   always_comb begin
      next_state = state;
      next_step = step;
      next_ext_op = ext_op;
      next_op_wr = op_wr;
      next_op_reg = op_reg;
      next_wdata_r = wdata_r;
      next_ext_addr = ext_addr;
      next_ext_ctrl = ext_ctrl;
      next_result = result;
      next_done = done;
      next_req = 1'b0;
      next_wr = wr;
      next_reg_addr = reg_addr;
      next_wdata = wdata;
      next_rdata_o = 16'h0000;
      if (sw_rd_i) begin
         unique case (sw_addr_i)
            `EXA_SW_WDATA: next_rdata_o = wdata_r;
            `EXA_SW_RDATA: next_rdata_o = result;
            `EXA_SW_STATUS: begin
               next_rdata_o = {14'h0000, done, state != exa_pkg::ST_IDLE};
               next_done = 1'b0;
            end
            `EXA_SW_EXT_ADDR: next_rdata_o = ext_addr;
            `EXA_SW_EXT_CTRL: next_rdata_o = ext_ctrl;
            default: next_rdata_o = 16'h0000;
         endcase
      end
      if (sw_wr_i) begin
         unique case (sw_addr_i)
            `EXA_SW_CMD: begin
               // A command while busy is dropped.
               if (state == exa_pkg::ST_IDLE) begin
                  next_ext_op = sw_wdata_i[`EXA_CMD_EXT_BIT];
                  next_op_wr = sw_wdata_i[`EXA_CMD_WR_BIT];
                  next_op_reg = sw_wdata_i[4:0];
                  // Skipping the address load relies on an earlier setup.
                  next_step = (sw_wdata_i[`EXA_CMD_EXT_BIT] && !ext_ctrl[`EXA_EXT_SKIP_BIT])
                     ? 2'h0 : 2'h2;
                  next_state = exa_pkg::ST_ISSUE;
               end
            end
            `EXA_SW_WDATA: next_wdata_r = sw_wdata_i;
            `EXA_SW_EXT_ADDR: next_ext_addr = sw_wdata_i;
            `EXA_SW_EXT_CTRL: next_ext_ctrl = sw_wdata_i;
            default: next_wdata_r = wdata_r;
         endcase
      end
      unique case (state)
         exa_pkg::ST_IDLE: next_req = 1'b0;
         exa_pkg::ST_ISSUE: begin
            next_req = 1'b1;
            next_state = exa_pkg::ST_WAIT;
            if (!ext_op) begin
               next_wr = op_wr;
               next_reg_addr = op_reg;
               next_wdata = wdata_r;
            end else begin
               next_wr = (step != 2'h3) || op_wr;
               unique case (step)
                  2'h0: begin
                     next_reg_addr = `EXA_CTRL_IDX;
                     next_wdata = {11'h000, ext_ctrl[4:0]};
                  end
                  2'h1: begin
                     next_reg_addr = `EXA_DATA_IDX;
                     // Spaces other than the standard one drop the top nibble.
                     next_wdata = (ext_ctrl[4:0] == `EXA_SPACE_STD) ? ext_addr
                        : (ext_addr & `EXA_NIBBLE_MASK);
                  end
                  2'h2: begin
                     next_reg_addr = `EXA_CTRL_IDX;
                     // Function 10, or 11 for writes only, gives a burst on repeated data commands that skip the address load.
                     next_wdata = {ext_ctrl[15:14], 9'h000, ext_ctrl[4:0]};
                  end
                  default: begin
                     next_reg_addr = `EXA_DATA_IDX;
                     next_wdata = wdata_r;
                  end
               endcase
            end
         end
         exa_pkg::ST_WAIT: begin
            if (mgmt.ack) begin
               if (!ext_op || step == 2'h3) begin
                  if (!wr) begin
                     next_result = mgmt.rdata;
                  end
                  next_done = 1'b1; // Set wins over a same-cycle status read.
                  next_state = exa_pkg::ST_IDLE;
               end else begin
                  next_step = step + 2'h1;
                  next_state = exa_pkg::ST_ISSUE;
               end
            end
         end
         default: next_state = exa_pkg::ST_IDLE;
      endcase
   end

   // Register stage.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state <= exa_pkg::ST_IDLE;
         step <= 2'h0;
         ext_op <= 1'b0;
         op_wr <= 1'b0;
         op_reg <= 5'h00;
         wdata_r <= 16'h0000;
         ext_addr <= 16'h0000;
         ext_ctrl <= 16'h0000;
         result <= 16'h0000;
         done <= 1'b0;
         req <= 1'b0;
         wr <= 1'b0;
         reg_addr <= 5'h00;
         wdata <= 16'h0000;
         rdata_o <= 16'h0000;
      end else begin
         state <= next_state;
         step <= next_step;
         ext_op <= next_ext_op;
         op_wr <= next_op_wr;
         op_reg <= next_op_reg;
         wdata_r <= next_wdata_r;
         ext_addr <= next_ext_addr;
         ext_ctrl <= next_ext_ctrl;
         result <= next_result;
         done <= next_done;
         req <= next_req;
         wr <= next_wr;
         reg_addr <= next_reg_addr;
         wdata <= next_wdata;
         rdata_o <= next_rdata_o;
      end
   end

   assign mgmt.req = req;
   assign mgmt.wr = wr;
   assign mgmt.reg_addr = reg_addr;
   assign mgmt.wdata = wdata;
   assign sw_rdata_o = rdata_o;
endmodule

// File: exa_link_checker.sv
// Concurrent checks on the management link between the two ends.
`include "exa_consts.svh"
`timescale 1ns/100ps
module exa_link_checker (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic req,
   input wire logic wr,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic [15:0] rdata
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic [15:0] sh_ctrl; // Shadow of the control register.
   logic [15:0] sh_ptr; // Shadow of the address pointer.
   logic [15:0] sh_mem [0:63]; // Shadow of four spaces of sixteen words.
   logic [63:0] sh_val; // Shadow words known to hold data.
   logic [15:0] exp_word; // Shadow word under the pointer.
   logic good; // The control register names a supported space.
   logic [5:0] idx; // Shadow slot under the pointer.
   logic acc; // Data register access in a supported space.
   logic bump; // Access that must advance the pointer.
   logic cmd_rst; // Register command reset.
   // Decode the space and the kind of the current request.
   always_comb begin
      good = 1'b1;
      idx = {2'h0, sh_ptr[3:0]};
      case (sh_ctrl[4:0])
         `EXA_SPACE_STD: idx[5:4] = 2'h0;
         `EXA_SPACE_PMA: idx[5:4] = 2'h1;
         `EXA_SPACE_VA: idx[5:4] = 2'h2;
         `EXA_SPACE_VB: idx[5:4] = 2'h3;
         default: good = 1'b0;
      endcase
      exp_word = sh_mem[idx];
      acc = req && reg_addr == `EXA_DATA_IDX && good;
      bump = acc && (sh_ctrl[15:14] == 2'b10 || (sh_ctrl[15:14] == 2'b11 && wr));
      cmd_rst = req && wr && reg_addr == `EXA_RST_IDX && wdata[`EXA_RST_BIT];
   end
   // The model moves at the request edge; this is safe only because the
   // manager never issues again before the answer has come back.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || cmd_rst) begin
         sh_ctrl <= 16'h0000;
         sh_ptr <= 16'h0000;
         sh_val <= 64'h0;
      end else begin
         if (req && wr && reg_addr == `EXA_CTRL_IDX) begin
            sh_ctrl <= wdata;
         end
         if (acc && wr && sh_ctrl[15:14] == 2'b00) begin
            sh_ptr <= wdata;
         end else if (bump) begin
            sh_ptr <= sh_ptr + 16'h0001;
         end
         if (acc && wr && sh_ctrl[15:14] != 2'b00) begin
            sh_mem[idx] <= wdata;
            sh_val[idx] <= 1'b1;
         end
      end
   end
   a_req_answered: assert property (req |=> ack)
      else $error("request not answered in the next cycle");
   a_ack_caused: assert property (ack |-> $past(req))
      else $error("answer without a request");
   a_ack_single: assert property (ack |=> !ack)
      else $error("answer longer than one cycle");
   a_req_spaced: assert property (req |=> !req)
      else $error("request issued before the answer");
   a_ctrl_readback: assert property (
      req && !wr && reg_addr == `EXA_CTRL_IDX |=> rdata == sh_ctrl)
      else $error("control register read back wrong");
   a_ptr_readback: assert property (
      acc && !wr && sh_ctrl[15:14] == 2'b00 |=> rdata == sh_ptr)
      else $error("pointer read back wrong");
   a_data_readback: assert property (
      acc && !wr && sh_ctrl[15:14] != 2'b00 && sh_val[idx] |=> rdata == $past(exp_word))
      else $error("extended word read back wrong");
   a_bad_space_read: assert property (
      req && !wr && reg_addr == `EXA_DATA_IDX && !good |=> rdata == 16'h0000)
      else $error("read in an unsupported space not ignored");
   c_inc_read: cover property (bump && !wr);
   c_bad_space: cover property (req && reg_addr == `EXA_DATA_IDX && !good);
   c_cmd_reset: cover property (cmd_rst);
endmodule

// File: tb_extended_register_indirect_access.sv
// Testbench driving the manager's software port against the device end.
`include "exa_consts.svh"
`timescale 1ns/100ps
module tb_extended_register_indirect_access;
   logic clk_sys_i = 1'b0; // System clock, 4 ns period.
   logic rst_i = 1'b1; // Synchronous reset, active high.
   logic [2:0] sw_addr_i = 3'h0; // Software port offset.
   logic [15:0] sw_wdata_i = 16'h0000; // Software write data.
   logic sw_wr_i = 1'b0; // Software write strobe.
   logic sw_rd_i = 1'b0; // Software read strobe.
   logic [15:0] sw_rdata_o; // Software read data.
   logic [2:0] strap_mac_i = 3'h5; // Two-level straps, settled before reset ends.
   logic strap_ms_i = 1'b1;
   logic strap_auto_i = 1'b0;
   logic [1:0] strap_rxctrl_lvl_i = 2'h2; // Three-level straps: mode 3 and mode 2.
   logic [1:0] strap_strp1_lvl_i = 2'h1;
   logic [2:0] mac_mode_o;
   logic master_o;
   logic managed_o;
   logic [3:0] phy_addr_o;
   logic [15:0] rd; // Scratch for reads.
   logic [4:0] spaces [0:3] = '{5'h1f, 5'h01, 5'h03, 5'h07}; // Supported spaces.
   int num_errors = 0;
   int total_checks = 0;
   // Clock generator.
   always #2 clk_sys_i = ~clk_sys_i;
   exa_mgmt_if link ();
   exa_phy_end exa_phy_end_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mgmt(link),
      .strap_mac_i(strap_mac_i), .strap_ms_i(strap_ms_i), .strap_auto_i(strap_auto_i),
      .strap_rxctrl_lvl_i(strap_rxctrl_lvl_i), .strap_strp1_lvl_i(strap_strp1_lvl_i),
      .mac_mode_o(mac_mode_o), .master_o(master_o), .managed_o(managed_o),
      .phy_addr_o(phy_addr_o));
   exa_mgr_end exa_mgr_end_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mgmt(link),
      .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
      .sw_rdata_o(sw_rdata_o));
   exa_link_checker exa_link_checker_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .req(link.req), .wr(link.wr), .reg_addr(link.reg_addr), .wdata(link.wdata),
      .ack(link.ack), .rdata(link.rdata));
   // Print the counts and the verdict, then end the run.
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Compare one 16-bit value; four-state equality so unknowns never match.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Write strobe for one cycle, then a quiet cycle so strobes never merge.
   task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
      sw_addr_i <= a;
      sw_wdata_i <= d;
      sw_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      sw_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic sw_read(input logic [2:0] a, output logic [15:0] q);
      sw_addr_i <= a;
      sw_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      sw_rd_i <= 1'b0;
      #1 q = sw_rdata_o;
      @(posedge clk_sys_i);
   endtask
   // Issue one command and poll the sticky done flag under a bound.
   task automatic run(input logic w, input logic x, input logic [4:0] r,
                      input logic [15:0] d, output logic [15:0] q);
      logic [15:0] s;
      int i;
      q = 16'h0000;
      if (w) begin
         sw_write(`EXA_SW_WDATA, d);
      end
      sw_write(`EXA_SW_CMD, {6'h00, x, w, 3'h0, r});
      for (i = 0; i < 40; i++) begin
         sw_read(`EXA_SW_STATUS, s);
         if (s[1] === 1'b1) break;
      end
      if (i == 40) begin
         num_errors++;
         $display("BAD at %0t: command never completed", $time);
         report_and_stop();
      end
      if (!w) begin
         sw_read(`EXA_SW_RDATA, q);
      end
   endtask
   task automatic dw(input logic [4:0] r, input logic [15:0] d);
      run(1'b1, 1'b0, r, d, rd);
   endtask
   task automatic chk_rd(input logic [4:0] r, input logic [15:0] exp);
      logic [15:0] q;
      run(1'b0, 1'b0, r, 16'h0000, q);
      chk(q, exp, "register read");
   endtask
   task automatic ctl(input logic [1:0] f, input logic [4:0] s);
      dw(`EXA_CTRL_IDX, {f, 9'h000, s});
   endtask
   task automatic set_ptr(input logic [4:0] s, input logic [15:0] a);
      ctl(2'b00, s);
      dw(`EXA_DATA_IDX, a);
   endtask
   // The outputs packed in the layout of the configuration register.
   task automatic chk_cfg(input logic [15:0] exp);
      chk({7'h00, phy_addr_o, managed_o, master_o, mac_mode_o}, exp, "config outputs");
   endtask
   // Main sequence.
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      chk_cfg(16'h01ad);
      chk_rd(`EXA_CFG_IDX, 16'h01ad);
      dw(`EXA_CFG_IDX, 16'h0013);
      repeat (2) @(posedge clk_sys_i);
      chk_cfg(16'h0013);
      dw(5'h03, 16'h1234);
      chk_rd(5'h03, 16'h1234);
      set_ptr(5'h1f, 16'h0005);
      chk_rd(`EXA_DATA_IDX, 16'h0005);
      chk_rd(`EXA_DATA_IDX, 16'h0005);
      chk_rd(`EXA_CTRL_IDX, 16'h001f);
      ctl(2'b01, 5'h1f);
      dw(`EXA_DATA_IDX, 16'ha5a5);
      chk_rd(`EXA_DATA_IDX, 16'ha5a5);
      chk_rd(`EXA_DATA_IDX, 16'ha5a5);
      ctl(2'b00, 5'h1f);
      chk_rd(`EXA_DATA_IDX, 16'h0005);
      // Burst of two writes, then two reads; only one mode advances on reads.
      for (int f = 2; f < 4; f++) begin
         set_ptr(5'h1f, 16'h0006);
         ctl(f[1:0], 5'h1f);
         dw(`EXA_DATA_IDX, 16'h1100 | 16'(f));
         dw(`EXA_DATA_IDX, 16'h2200 | 16'(f));
         ctl(2'b00, 5'h1f);
         chk_rd(`EXA_DATA_IDX, 16'h0008);
         set_ptr(5'h1f, 16'h0006);
         ctl(f[1:0], 5'h1f);
         chk_rd(`EXA_DATA_IDX, 16'h1100 | 16'(f));
         chk_rd(`EXA_DATA_IDX, (f == 2) ? 16'h2202 : 16'h1103);
         ctl(2'b00, 5'h1f);
         chk_rd(`EXA_DATA_IDX, (f == 2) ? 16'h0008 : 16'h0006);
      end
      // Each space keeps its own word at the same pointer.
      foreach (spaces[k]) begin
         set_ptr(spaces[k], 16'h0002);
         ctl(2'b01, spaces[k]);
         dw(`EXA_DATA_IDX, {8'h5a, 3'h0, spaces[k]});
      end
      foreach (spaces[k]) begin
         ctl(2'b01, spaces[k]);
         chk_rd(`EXA_DATA_IDX, {8'h5a, 3'h0, spaces[k]});
      end
      ctl(2'b01, 5'h02);
      dw(`EXA_DATA_IDX, 16'hdead);
      chk_rd(`EXA_DATA_IDX, 16'h0000);
      ctl(2'b01, 5'h01);
      chk_rd(`EXA_DATA_IDX, 16'h5a01);
      // Manager-driven extended write; the top address nibble must be dropped.
      sw_write(`EXA_SW_EXT_ADDR, 16'h1904);
      sw_write(`EXA_SW_EXT_CTRL, 16'h4001);
      run(1'b1, 1'b1, 5'h00, 16'hbeef, rd);
      ctl(2'b00, 5'h01);
      chk_rd(`EXA_DATA_IDX, 16'h0904);
      sw_write(`EXA_SW_EXT_CTRL, 16'h6001);
      run(1'b0, 1'b1, 5'h00, 16'h0000, rd);
      chk(rd, 16'hbeef, "extended read");
      sw_read(`EXA_SW_EXT_ADDR, rd);
      chk(rd, 16'h1904, "extended address readback");
      // The standard space keeps the top nibble; a skipped setup then bursts on.
      sw_write(`EXA_SW_EXT_ADDR, 16'h1003);
      sw_write(`EXA_SW_EXT_CTRL, 16'h401f);
      run(1'b1, 1'b1, 5'h00, 16'h7777, rd);
      sw_write(`EXA_SW_EXT_CTRL, 16'ha01f);
      run(1'b1, 1'b1, 5'h00, 16'h8888, rd);
      run(1'b1, 1'b1, 5'h00, 16'h9999, rd);
      ctl(2'b00, 5'h1f);
      chk_rd(`EXA_DATA_IDX, 16'h1005);
      set_ptr(5'h1f, 16'h1003);
      ctl(2'b10, 5'h1f);
      chk_rd(`EXA_DATA_IDX, 16'h8888);
      chk_rd(`EXA_DATA_IDX, 16'h9999);
      // A second command written while the manager is busy must be dropped.
      sw_write(`EXA_SW_WDATA, 16'h4444);
      sw_write(`EXA_SW_CMD, 16'h0104);
      sw_write(`EXA_SW_CMD, 16'h0105);
      repeat (8) @(posedge clk_sys_i);
      sw_read(`EXA_SW_STATUS, rd);
      chk(rd, 16'h0002, "status after one command");
      chk_rd(5'h04, 16'h4444);
      chk_rd(5'h05, 16'h0000);
      sw_read(3'h7, rd);
      chk(rd, 16'h0000, "unmapped offset");
      // New strap levels are taken again by the register command reset.
      strap_mac_i <= 3'h2;
      strap_ms_i <= 1'b0;
      strap_auto_i <= 1'b1;
      strap_rxctrl_lvl_i <= 2'h0;
      strap_strp1_lvl_i <= 2'h2;
      dw(`EXA_RST_IDX, 16'h8000);
      repeat (4) @(posedge clk_sys_i);
      chk_cfg(16'h0152);
      chk_rd(`EXA_RST_IDX, 16'h0000);
      chk_rd(`EXA_CTRL_IDX, 16'h0000);
      report_and_stop();
   end
endmodule
